// ---- hw/ext_irq_map.vh ----
// Functional notes
// R1: first input active low when cfg bit 3 is 0, active high when 1.
// R2: second input active low when cfg bit 7 is 0, active high when 1.
// R3: sense-type bit 1 gives edge mode, 0 gives level mode.
// R4: cfg bits 2-0 and 6-4 pick the port-0 pin for each input.
// R5: pin sampling is independent of crossbar and never disturbs the pin.
// R6: crossbar gives no pin to a peripheral while its skip bit is 1.
// R7: pending flags sit at timer control bits 1 and 3.
// R8: edge mode pending flag clears in hardware when the cpu vectors.
// R9: level mode pending flag follows the active level of the input.
// R10: level source holds its input active until the request is recognised.
// R11: level source drops its input before the service routine ends.
// R12: software should skip irq pins, use open-drain, and latch them high.
// R13: edge mode synchronises the pin and sets pending on inactive-to-active edge.
// R14: request reaches cpu only with its mask bit and global enable set.
// R15: priority bit 0 selects low level, 1 selects high level.
`ifndef EXT_IRQ_MAP_VH
`define EXT_IRQ_MAP_VH
// ==========================================
// register addresses
`define CFG_ADDR 8'he4
`define TCTL_ADDR 8'h88
`define IE_ADDR 8'ha8
`define IP_ADDR 8'hb8
`define SKIP_ADDR 8'hd4
// ==========================================
// field positions and reset values
`define CFG_RESET 8'h01
`define CFG_FIRST_POL 3
`define CFG_SECOND_POL 7
`define TCTL_FIRST_TYPE 0
`define TCTL_FIRST_PEND 1
`define TCTL_SECOND_TYPE 2
`define TCTL_SECOND_PEND 3
`define IE_FIRST_MASK 0
`define IE_SECOND_MASK 2
`define IE_GLOBAL 7
`define IP_FIRST_PRIO 0
`define IP_SECOND_PRIO 2
`define IP_RESET 8'h80
`endif

// ---- hw/ext_irq_channel.v ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// one external interrupt channel: pin select, sync, sense
module ext_irq_channel (
   input wire i_clk,
   input wire i_rst_n,
   input wire [7:0] i_port,
   input wire [2:0] i_sel,
   input wire i_pol,
   input wire i_edge,
   input wire i_clr,
   input wire i_sw_wr,
   input wire i_sw_val,
   output wire o_pending
);
   reg [2:0] sync_ff;
   reg act_ff;
   reg pend_ff;
   wire [2:0] nxt_sync;
   wire stable;
   wire level_act;
   wire rise;
   // pin only read, never driven, so the crossbar owner is undisturbed
   assign nxt_sync = {sync_ff[1:0], i_port[i_sel]}; // R4 R5
   // accept a change only when stage two and three agree
   assign stable = (sync_ff[1] == sync_ff[2]);
   assign level_act = i_pol ? sync_ff[2] : ~sync_ff[2]; // R1 R2
   assign rise = stable & level_act & ~act_ff; // R13
   // filtered active level and pending flag
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         // match the pulled-up idle pin so no false edge follows reset
         sync_ff <= 3'h7;
         act_ff <= 1'b0;
         pend_ff <= 1'b0;
      end else begin
         sync_ff <= nxt_sync;
         if (stable) begin
            act_ff <= level_act;
         end
         if (!i_edge) begin
            pend_ff <= stable ? level_act : act_ff; // R3 R9
         end else if (rise) begin
            pend_ff <= 1'b1; // set beats clear R13
         end else if (i_clr) begin
            pend_ff <= 1'b0; // R8
         end else if (i_sw_wr) begin
            pend_ff <= i_sw_val;
         end
      end
   end
   assign o_pending = pend_ff; // R7
endmodule
`default_nettype wire

// ---- hw/ext_irq_top.v ----
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_map.vh"
// ==========================================
// two external interrupt inputs with sfr access
module ext_irq_top (
   // clock and reset
   input wire I_MCLK,
   input wire I_RST_N,
   // port 0 pins, sampled only
   input wire [7:0] I_PORT0,
   // sfr bus
   input wire I_SFR_WR,
   input wire I_SFR_RD,
   input wire [7:0] I_SFR_ADDR,
   input wire [7:0] I_SFR_WDATA,
   output reg [7:0] O_SFR_RDATA,
   // cpu vector acknowledge
   input wire I_ACK_FIRST,
   input wire I_ACK_SECOND,
   // requests to cpu
   output reg O_REQ_FIRST,
   output reg O_REQ_SECOND,
   output reg O_PRIO_FIRST,
   output reg O_PRIO_SECOND,
   // crossbar skip mask
   output reg [7:0] O_XBAR_SKIP
);
   reg [7:0] cfg_ff;
   reg [1:0] type_ff;
   reg [7:0] ie_ff;
   reg [6:0] ip_ff;
   reg [7:0] skip_ff;
   wire [1:0] pend;
   wire [1:0] pend_wr;
   wire [7:0] tctl_rd;
   reg [7:0] nxt_rdata;
   wire tctl_wr;
   assign tctl_wr = I_SFR_WR & (I_SFR_ADDR == `TCTL_ADDR);
   assign pend_wr = {tctl_wr, tctl_wr};
   // ==========================================
   // channels
   ext_irq_channel u_first (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_port(I_PORT0),
      .i_sel(cfg_ff[2:0]), // R4
      .i_pol(cfg_ff[`CFG_FIRST_POL]), // R1
      .i_edge(type_ff[0]), // R3
      .i_clr(I_ACK_FIRST), // R8
      .i_sw_wr(pend_wr[0]),
      .i_sw_val(I_SFR_WDATA[`TCTL_FIRST_PEND]),
      .o_pending(pend[0])
   );
   ext_irq_channel u_second (
      .i_clk(I_MCLK),
      .i_rst_n(I_RST_N),
      .i_port(I_PORT0),
      .i_sel(cfg_ff[6:4]), // R4
      .i_pol(cfg_ff[`CFG_SECOND_POL]), // R2
      .i_edge(type_ff[1]), // R3
      .i_clr(I_ACK_SECOND), // R8
      .i_sw_wr(pend_wr[1]),
      .i_sw_val(I_SFR_WDATA[`TCTL_SECOND_PEND]),
      .o_pending(pend[1])
   );
   // other timer control bits belong to the timers and read zero here
   assign tctl_rd = {4'h0, pend[1], type_ff[1], pend[0], type_ff[0]}; // R7
   // ==========================================
   // register writes
   always @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         cfg_ff <= `CFG_RESET;
         type_ff <= 2'h0;
         ie_ff <= 8'h00;
         ip_ff <= 7'h00;
         skip_ff <= 8'h00;
      end else if (I_SFR_WR) begin
         case (I_SFR_ADDR)
            `CFG_ADDR: begin
               cfg_ff <= I_SFR_WDATA;
            end
            `TCTL_ADDR: begin
               type_ff <= {I_SFR_WDATA[`TCTL_SECOND_TYPE], I_SFR_WDATA[`TCTL_FIRST_TYPE]}; // R3
            end
            `IE_ADDR: begin
               ie_ff <= I_SFR_WDATA;
            end
            `IP_ADDR: begin
               ip_ff <= I_SFR_WDATA[6:0];
            end
            `SKIP_ADDR: begin
               skip_ff <= I_SFR_WDATA; // R6
            end
            default: begin
               skip_ff <= skip_ff;
            end
         endcase
      end
   end
   // read mux; unmapped reads give zero
   always @* begin
      case (I_SFR_ADDR)
         `CFG_ADDR: nxt_rdata = cfg_ff;
         `TCTL_ADDR: nxt_rdata = tctl_rd;
         `IE_ADDR: nxt_rdata = ie_ff;
         `IP_ADDR: nxt_rdata = {1'b1, ip_ff};
         `SKIP_ADDR: nxt_rdata = skip_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end
   // registered outputs
   always @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         O_SFR_RDATA <= 8'h00;
         O_REQ_FIRST <= 1'b0;
         O_REQ_SECOND <= 1'b0;
         O_PRIO_FIRST <= 1'b0;
         O_PRIO_SECOND <= 1'b0;
         O_XBAR_SKIP <= 8'h00;
      end else begin
         if (I_SFR_RD) begin
            O_SFR_RDATA <= nxt_rdata;
         end
         O_REQ_FIRST <= pend[0] & ie_ff[`IE_FIRST_MASK] & ie_ff[`IE_GLOBAL]; // R14
         O_REQ_SECOND <= pend[1] & ie_ff[`IE_SECOND_MASK] & ie_ff[`IE_GLOBAL]; // R14
         O_PRIO_FIRST <= ip_ff[`IP_FIRST_PRIO]; // R15
         O_PRIO_SECOND <= ip_ff[`IP_SECOND_PRIO]; // R15
         O_XBAR_SKIP <= skip_ff; // R6
      end
   end
endmodule
`default_nettype wire

// ---- bench/irq_pin_src.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// pin sources on port 0
module irq_pin_src (input wire logic i_clk, input wire logic [7:0] i_drive, output logic [7:0] o_port);
   // idle pins rest high, as open-drain with latch at one
   initial o_port = 8'hff;
   // a level is held until the bench drops it
   always @(posedge i_clk) o_port <= i_drive;
endmodule
`default_nettype wire

// ---- bench/ext_irq_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker
module ext_irq_checker (
   // bus, cpu and crossbar side
   input wire logic I_MCLK, I_RST_N, I_SFR_WR, I_SFR_RD, O_REQ_FIRST, O_REQ_SECOND, O_PRIO_FIRST, O_PRIO_SECOND,
   input wire logic [7:0] I_SFR_ADDR, I_SFR_WDATA, O_SFR_RDATA, O_XBAR_SKIP
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   // decoded write strobes
   wire logic [7:0] a = I_SFR_ADDR;
   wire logic w_ie = I_SFR_WR && a == 8'ha8;
   wire logic w_ip = I_SFR_WR && a == 8'hb8;
   wire logic w_sk = I_SFR_WR && a == 8'hd4;
   chk_rd_hold: assert property (!I_SFR_RD |=> $stable(O_SFR_RDATA)) else $error("rdata moved");
   chk_tctl_spare: assert property (I_SFR_RD && a == 8'h88 |=> O_SFR_RDATA[7:4] == 4'h0) else $error("spare");
   chk_skip_out: assert property (w_sk ##1 !w_sk |=> O_XBAR_SKIP == $past(I_SFR_WDATA, 2)) else $error("skip");
   chk_prio_out: assert property (w_ip ##1 !w_ip |=>
      {5'h0, O_PRIO_SECOND, 1'b0, O_PRIO_FIRST} == ($past(I_SFR_WDATA, 2) & 8'h05)) else $error("prio");
   chk_ie_gate: assert property (w_ie && !I_SFR_WDATA[7] ##1 !w_ie |=> !O_REQ_FIRST && !O_REQ_SECOND)
      else $error("gate");
   chk_ie_read: assert property (w_ie ##1 I_SFR_RD && a == 8'ha8 |=>
      (O_SFR_RDATA & 8'h85) == ($past(I_SFR_WDATA, 2) & 8'h85)) else $error("ie");
   chk_cfg_read: assert property (I_SFR_WR && a == 8'he4 ##1 I_SFR_RD && a == 8'he4 |=>
      O_SFR_RDATA == $past(I_SFR_WDATA, 2)) else $error("cfg");
   chk_ip_top: assert property (I_SFR_RD && a == 8'hb8 |=> O_SFR_RDATA[7]) else $error("ip");
endmodule
bind ext_irq_top ext_irq_checker i_chk (.I_MCLK, .I_RST_N, .I_SFR_WR, .I_SFR_RD, .O_REQ_FIRST, .O_REQ_SECOND,
   .O_PRIO_FIRST, .O_PRIO_SECOND, .I_SFR_ADDR, .I_SFR_WDATA, .O_SFR_RDATA, .O_XBAR_SKIP);
`default_nettype wire

// ---- bench/external_interrupt_inputs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// random channel bench
module external_interrupt_inputs_tb;
   logic clk = 0, rst_n = 0, edg;
   logic [1:0] op = 0, ack = 0, req;
   logic [7:0] adr = 0, wd = 0, drv = 8'hff, port, rd, cfg, ie, d;
   int miscompares = 0, num_checks = 0, seed = 32'h51d2;
   // free-running clock
   always #2.5 clk = ~clk;
   irq_pin_src i_src (.i_clk(clk), .i_drive(drv), .o_port(port));
   ext_irq_top i_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_PORT0(port), .I_SFR_WR(op[1]), .I_SFR_RD(op[0]),
      .I_SFR_ADDR(adr), .I_SFR_WDATA(wd), .O_SFR_RDATA(rd), .I_ACK_FIRST(ack[0]), .I_ACK_SECOND(ack[1]),
      .O_REQ_FIRST(req[0]), .O_REQ_SECOND(req[1]), .O_PRIO_FIRST(), .O_PRIO_SECOND(), .O_XBAR_SKIP());
   // active state of each selected pin
   function automatic logic [1:0] act(input logic [7:0] p);
      return {p[cfg[6:4]] == cfg[7], p[cfg[2:0]] == cfg[3]};
   endfunction
   task automatic chk(input logic [7:0] g, e);
      num_checks++;
      miscompares += (g !== e);
      if (g !== e) $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
   endtask
   // access held over one edge, data settled after it
   task automatic acc(input logic [1:0] o, input logic [7:0] a, w);
      {op, adr, wd} <= {o, a, w};
      @(posedge clk);
      #1;
   endtask
   // ack pulse, then wait out sync and filter
   task automatic pulse(input logic [1:0] k);
      {op, ack} <= {2'b00, k};
      @(posedge clk);
      ack <= 0;
      repeat (8) @(posedge clk);
      #1;
   endtask
   // requests, then pending flags
   task automatic look(input logic [1:0] e);
      chk({6'h0, req}, {6'h0, e & {ie[2], ie[0]} & {2{ie[7]}}});
      acc(1, 8'h88, 0);
      chk(rd, {4'h0, e[1], edg, e[0], edg});
   endtask
   task automatic conclude;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // reset, then random channels in both sense modes
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      acc(1, 8'he4, 0);
      chk(rd, 8'h01);
      for (int i = 0; i < 24; i++) begin
         {edg, cfg, ie, d} = 25'($random(seed));
         drv <= ~d;
         acc(2, 8'he4, cfg);
         acc(1, 8'he4, 0);
         chk(rd, cfg);
         acc(2, 8'ha8, ie);
         acc(1, 8'ha8, 0);
         chk(rd, ie);
         acc(2, 8'hd4, ie);
         acc(2, 8'hb8, cfg);
         acc(1, 8'hb8, 0);
         chk(rd, {1'b1, cfg[6:0]});
         acc(2, 8'h88, {5'h0, edg, 1'b0, edg});
         pulse(3);
         drv <= d;
         pulse(0);
         look(act(d));
         if (!edg) drv <= ~d;
         pulse({2{edg}});
         look(edg ? 2'b00 : ~act(d));
      end
      conclude();
   end
endmodule
`default_nettype wire
